// *** ssc_ctrl_regs.vh ***
// constants for the sensor startup and mode controller
`ifndef SSC_CTRL_REGS_VH
`define SSC_CTRL_REGS_VH
// ************************************************************
// register offsets
// ************************************************************
`define SSC_REG_CTRL      4'h0
`define SSC_REG_MODE      4'h1
`define SSC_REG_LIMLO     4'h2
`define SSC_REG_LIMHI     4'h3
`define SSC_REG_RESULT    4'h4
`define SSC_REG_STATUS    4'h5
`define SSC_REG_WDKICK    4'h6
`define SSC_REG_DACCODE   4'h7
// ************************************************************
// field values and reset values
// ************************************************************
`define SSC_PIN_DIGITAL   2'h0
`define SSC_PIN_WINDOWED  2'h1
`define SSC_PIN_ANAWIN    2'h2
`define SSC_PIN_DISABLED  2'h3
`define SSC_ERROR_CODE    16'hFFFF
`define SSC_LIMLO_RST     15'h0000
`define SSC_LIMHI_RST     15'h7FFF
// ************************************************************
// timing figures in microseconds, clock rates in MHz and the start conversion count, nominal at the 3 MHz oscillator
// ************************************************************
`define SSC_T_POR_US      500
`define SSC_T_SYSSTART_US 200
`define SSC_T_WINDOW_US   500000
`define SSC_T_WDOG_US     100000
`define SSC_CLK_MHZ       25
`define SSC_OSC_MHZ       3
`define SSC_CONV_STARTS   5
`endif

// *** ssc_ctrl.v ***
// sensor startup sequencer, mode control, output pin and failsafe logic
// ************************************************************
// ************************************************************
`timescale 1ns/100ps
`default_nettype none
`include "ssc_ctrl_regs.vh"

// ************************************************************
// timing model
// ************************************************************
// the settling and window spans count fast clocks, the system start counts
// oscillator ticks, and the start routine counts finished conversions.
// a slow oscillator therefore stretches the system start and the start
// routine exactly as the real sequencer would, while the settling span
// stays fixed because the oscillator is not trusted before it ends.
// the defaults give the nominal spans; a bench may shorten all of them but the start routine, fixed at SSC_CONV_STARTS conversions.
// failure is sticky: only a new power-on reset leaves the failure state.

module ssc_ctrl #(
  parameter integer POR_CYC    = (`SSC_T_POR_US * `SSC_CLK_MHZ),
  parameter integer SYS_CYC    = (`SSC_T_SYSSTART_US * `SSC_OSC_MHZ),
  parameter integer WINDOW_CYC = (`SSC_T_WINDOW_US * `SSC_CLK_MHZ),
  parameter integer WDOG_CYC   = (`SSC_T_WDOG_US * `SSC_CLK_MHZ),
  parameter integer OSC_TIMEOUT = 64
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire [3:0]  regAddr,
  input  wire [15:0] regWdata,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [15:0] regRdata,
  input  wire        oscTick,
  input  wire        convDone,
  input  wire [14:0] convResult,
  input  wire        sigCheckOk,
  input  wire        memCheckErr,
  input  wire        enterCmdReq,
  input  wire        wireReadReq,
  input  wire [1:0]  cfgPinMode,
  input  wire        cfgResolution,
  input  wire [1:0]  cfgMuxSeq,
  output reg  [1:0]  workMode,
  output reg  [1:0]  muxSelect,
  output reg  [13:0] convLength,
  output reg  [15:0] dacCode,
  output reg         sharedOutputPinOe,
  output reg         sharedOutputPinLow,
  output reg         wireReadGrant,
  output reg         failureFlag
);
  // ************************************************************
  // state codes
  // ************************************************************
  localparam [2:0] ST_POR = 3'd0, ST_SYS = 3'd1, ST_MSTART = 3'd2, ST_RUN = 3'd3,
                   ST_CMD = 3'd4, ST_FAIL = 3'd5;
  localparam [1:0] WM_NORMAL = 2'd0, WM_CMD = 2'd1, WM_FAIL = 2'd2;
  localparam [1:0] MUX_BRIDGE = 2'd0, MUX_TEMP = 2'd1, MUX_OFFSET = 2'd2;

  // ************************************************************
  // input synchronisers for pins and asynchronous sources
  // ************************************************************
  // every source that is not born on clk passes two flops; only the
  // second stage is read, so a metastable first stage never fans out.
  // the oscillator edge detector idles low like the synchronised tick,
  // so no false edge follows the release of reset.
  reg [3:0] syncA;
  reg [3:0] syncB;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncA <= 4'h0;
      syncB <= 4'h0;
    end else begin
      syncA <= {oscTick, enterCmdReq, wireReadReq, memCheckErr};
      syncB <= syncA;
    end
  end
  wire memErrS  = syncB[0];
  wire readReqS = syncB[1];
  wire cmdReqS  = syncB[2];
  wire oscS     = syncB[3];
  reg  oscPrev;
  wire oscEdge  = oscS & ~oscPrev;

  // even parity over a 16-bit word, used on every control register.
  // one function keeps the stored and the recomputed parity identical,
  // so a flipped register bit is the only thing that can make them differ.
  // the check is combinational and is seen in the very next clock.
  function parity16;
    input [15:0] w;
    begin
      parity16 = ^w;
    end
  endfunction

  // ************************************************************
  // control registers with parity
  // ************************************************************
  reg  [1:0]  pinMode;
  reg         resBits;
  reg  [14:0] limLo;
  reg  [14:0] limHi;
  reg  [2:0]  ctrlPar;
  reg         wdKick;
  reg  [2:0]  state;
  reg  [31:0] phaseCnt;
  reg  [31:0] wdCnt;
  reg  [7:0]  oscWatch;
  reg  [2:0]  convCnt;
  reg         windowOpen;
  reg         windowGone;
  reg  [14:0] result;
  reg  [1:0]  seqPos;
  reg         started;
  wire parityErr = (ctrlPar[0] != parity16({13'h0000, resBits, pinMode})) |
                   (ctrlPar[1] != parity16({1'b0, limLo})) |
                   (ctrlPar[2] != parity16({1'b0, limHi}));
  wire wdErr   = (wdCnt >= WDOG_CYC);
  wire oscErr  = (oscWatch >= OSC_TIMEOUT[7:0]);
  wire anyFail = parityErr | wdErr | oscErr | memErrS;

  // configuration load at start, software writes afterwards
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinMode <= `SSC_PIN_DIGITAL;
      resBits <= 1'b0;
      limLo   <= `SSC_LIMLO_RST;
      limHi   <= `SSC_LIMHI_RST;
      ctrlPar <= 3'b100;                  // parity of the reset limits, all-ones upper limit
      wdKick  <= 1'b0;
    end else begin
      wdKick <= regWrite && regAddr == `SSC_REG_WDKICK;
      if (state == ST_SYS && phaseCnt == 32'd0) begin
        pinMode    <= cfgPinMode;
        resBits    <= cfgResolution;
        ctrlPar[0] <= parity16({13'h0000, cfgResolution, cfgPinMode});
      end else if (regWrite && regAddr == `SSC_REG_MODE) begin
        pinMode    <= regWdata[1:0];
        resBits    <= regWdata[2];
        ctrlPar[0] <= parity16({13'h0000, regWdata[2:0]});
      end
      if (regWrite && regAddr == `SSC_REG_LIMLO) begin
        limLo      <= regWdata[14:0];
        ctrlPar[1] <= parity16({1'b0, regWdata[14:0]});
      end
      if (regWrite && regAddr == `SSC_REG_LIMHI) begin
        limHi      <= regWdata[14:0];
        ctrlPar[2] <= parity16({1'b0, regWdata[14:0]});
      end
    end
  end

  // ************************************************************
  // watchdog and oscillator monitor
  // ************************************************************
  // the monitor counts fast clocks between oscillator ticks; a stuck oscillator trips it.
  // both counters saturate at their limit, so the error level holds and
  // cannot wrap back to a clean count while the failure is being raised.
  // the watchdog only runs in normal conditioning; startup and command
  // mode hold it cleared because software cannot kick it there.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdCnt    <= 32'd0;
      oscWatch <= 8'd0;
      oscPrev  <= 1'b0;
    end else begin
      oscPrev <= oscS;
      if (wdKick || state != ST_RUN)
        wdCnt <= 32'd0;
      else if (!wdErr)
        wdCnt <= wdCnt + 32'd1;
      if (oscEdge)
        oscWatch <= 8'd0;
      else if (!oscErr)
        oscWatch <= oscWatch + 8'd1;
    end
  end

  // ************************************************************
  // startup sequencer and working mode
  // ************************************************************
  // the system start count advances on oscillator ticks so it scales with its frequency.
  // a failure overrides every phase except settling, where the monitors
  // are not yet meaningful. the signature verdict is taken once, at the
  // end of system start; a bad signature never reaches the start routine.
  // the window counter reuses the phase counter, which system start has
  // cleared, so the window is measured from entry into normal mode.
  // once the window has closed the command request is ignored for good,
  // because windowOpen can only be set again by a new start.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state      <= ST_POR;
      phaseCnt   <= 32'd0;
      convCnt    <= 3'd0;
      windowOpen <= 1'b0;
      windowGone <= 1'b0;
      started    <= 1'b0;
    end else begin
      if (anyFail && state != ST_POR) begin
        state <= ST_FAIL;
      end else begin
        case (state)
          ST_POR: begin
            if (phaseCnt >= POR_CYC) begin
              state    <= ST_SYS;
              phaseCnt <= 32'd0;
            end else
              phaseCnt <= phaseCnt + 32'd1;
          end
          ST_SYS: begin
            if (phaseCnt >= SYS_CYC) begin
              phaseCnt <= 32'd0;
              convCnt  <= 3'd0;
              state    <= sigCheckOk ? ST_MSTART : ST_FAIL;
            end else if (oscEdge)
              phaseCnt <= phaseCnt + 32'd1;
          end
          ST_MSTART: begin
            if (convCnt == `SSC_CONV_STARTS) begin
              state      <= ST_RUN;
              windowOpen <= (pinMode == `SSC_PIN_WINDOWED) ||
                            (pinMode == `SSC_PIN_ANAWIN);
              started    <= 1'b1;
            end else if (convDone)
              convCnt <= convCnt + 3'd1;
          end
          ST_RUN: begin
            if (windowOpen) begin
              if (cmdReqS) begin
                state      <= ST_CMD;
                windowOpen <= 1'b0;
              end else if (phaseCnt >= WINDOW_CYC) begin
                windowOpen <= 1'b0;
                windowGone <= 1'b1;
              end else
                phaseCnt <= phaseCnt + 32'd1;
            end
          end
          ST_CMD: state <= ST_CMD;
          ST_FAIL: state <= ST_FAIL;
          default: state <= ST_FAIL;
        endcase
      end
    end
  end

  // ************************************************************
  // measurement multiplexer sequence and result capture
  // ************************************************************
  // sequence code picks how often the bridge is revisited between side channels.
  // only bridge conversions update the result; temperature and offset
  // samples feed the conditioning, which lies outside this block.
  // the result stays readable unclipped; clipping is for the analogue path only.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seqPos <= 2'd0;
      result <= 15'h0000;
    end else if (convDone && state >= ST_MSTART) begin
      seqPos <= (seqPos >= {1'b0, cfgMuxSeq[0]} + 2'd2) ? 2'd0 : seqPos + 2'd1;
      if (muxSelect == MUX_BRIDGE)
        result <= convResult;
    end
  end

  // clipped value for the analogue path, 12.4-bit code from the 15-bit fraction
  wire [14:0] clipped = (result < limLo) ? limLo :
                        (result > limHi) ? limHi : result;
  wire analogueOn = (state == ST_RUN) && !windowOpen && (pinMode != `SSC_PIN_DIGITAL) ||
                    (state == ST_RUN) && (pinMode == `SSC_PIN_ANAWIN);

  // ************************************************************
  // registered outputs
  // ************************************************************
  // every output is a flop so the pin driver never sees decode glitches.
  // the pin stays released in settling, is held in the low range in
  // system start and failure, and follows the pin mode in the start
  // routine; in normal mode it drives analogue only when the mode allows.
  // command mode releases the pin so the external master can talk.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      workMode           <= WM_NORMAL;
      muxSelect          <= MUX_BRIDGE;
      convLength         <= 14'h0000;
      dacCode            <= 16'h0000;
      sharedOutputPinOe  <= 1'b0;
      sharedOutputPinLow <= 1'b0;
      wireReadGrant      <= 1'b0;
      failureFlag        <= 1'b0;
    end else begin
      workMode    <= (state == ST_FAIL) ? WM_FAIL :
                     (state == ST_CMD) ? WM_CMD : WM_NORMAL;
      muxSelect   <= (seqPos == 2'd0) ? MUX_BRIDGE :
                     (seqPos == 2'd1 && cfgMuxSeq[1]) ? MUX_OFFSET :
                     (seqPos == 2'd1) ? MUX_TEMP : MUX_OFFSET;
      // oscillator ticks per conversion, 2^r over fosc/2
      convLength  <= resBits ? 14'h2000 : 14'h1000;
      failureFlag <= (state == ST_FAIL);
      dacCode     <= {clipped[14:3], clipped[2:0], 1'b0};
      wireReadGrant <= readReqS && (state == ST_RUN) &&
                       (pinMode != `SSC_PIN_DISABLED);
      case (state)
        ST_POR: begin
          sharedOutputPinOe  <= 1'b0;
          sharedOutputPinLow <= 1'b0;
        end
        ST_SYS, ST_FAIL: begin
          sharedOutputPinOe  <= 1'b1;
          sharedOutputPinLow <= 1'b1;
        end
        ST_MSTART: begin
          sharedOutputPinOe  <= (pinMode == `SSC_PIN_ANAWIN) ||
                                (pinMode == `SSC_PIN_DISABLED);
          sharedOutputPinLow <= (pinMode == `SSC_PIN_ANAWIN) ||
                                (pinMode == `SSC_PIN_DISABLED);
        end
        ST_RUN: begin
          sharedOutputPinOe  <= analogueOn;
          sharedOutputPinLow <= 1'b0;
        end
        default: begin
          sharedOutputPinOe  <= 1'b0;
          sharedOutputPinLow <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // register read port, data one cycle after the strobe
  // ************************************************************
  // read data stand for one cycle only and are zero otherwise, so a bus
  // that ors several slaves together needs no extra select.
  // in failure mode the result reads as the error code, never stale data.
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      regRdata <= 16'h0000;
    else if (regRead) begin
      case (regAddr)
        `SSC_REG_MODE:    regRdata <= {13'h0000, resBits, pinMode};
        `SSC_REG_LIMLO:   regRdata <= {1'b0, limLo};
        `SSC_REG_LIMHI:   regRdata <= {1'b0, limHi};
        `SSC_REG_RESULT:  regRdata <= (state == ST_FAIL) ? `SSC_ERROR_CODE :
                                      {1'b0, result};
        `SSC_REG_STATUS:  regRdata <= {8'h00, windowGone, windowOpen, started,
                                      parityErr, oscErr, state};
        `SSC_REG_DACCODE: regRdata <= dacCode;
        default:          regRdata <= 16'h0000;
      endcase
    end else
      regRdata <= 16'h0000;
  end
endmodule // ssc_ctrl
`default_nettype wire

// *** ssc_ctrl_sva.sv ***
// assertion checker for the sensor startup and mode controller
`timescale 1ns/100ps
`default_nettype none
`include "ssc_ctrl_regs.vh"
module ssc_ctrl_sva #(
  parameter integer POR_CYC = 20
) (
  input wire        clk,
  input wire        resetn,
  input wire [3:0]  regAddr,
  input wire        regRead,
  input wire [15:0] regRdata,
  input wire        memCheckErr,
  input wire [1:0]  cfgPinMode,
  input wire        cfgResolution,
  input wire [1:0]  workMode,
  input wire [13:0] convLength,
  input wire        sharedOutputPinOe,
  input wire        sharedOutputPinLow,
  input wire        wireReadGrant,
  input wire        failureFlag
);
  // ************************************************************
  // helper: clocks since reset release, saturating at the settling length
  // ************************************************************
  reg [15:0] porCnt;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) porCnt <= 16'h0000;
    else if (porCnt < POR_CYC) porCnt <= porCnt + 16'h0001;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ************************************************************
  // properties
  // ************************************************************
  AST_MODE_LEGAL: assert property (workMode != 2'h3)
    else $error("work mode code out of range");
  AST_POR_HIZ: assert property (porCnt + 16'h0001 < POR_CYC |-> !sharedOutputPinOe)
    else $error("pin driven during supply settling");
  AST_FAIL_LOW: assert property (failureFlag |-> sharedOutputPinLow)
    else $error("failure without low diagnostic range");
  AST_FAIL_MODE: assert property (failureFlag |-> workMode == 2'h2)
    else $error("failure flag without failure mode");
  AST_FAIL_STICKY: assert property (failureFlag |=> failureFlag)
    else $error("failure mode left before reset");
  AST_ERR_CODE: assert property (regRead && regAddr == `SSC_REG_RESULT && failureFlag
    |=> regRdata == `SSC_ERROR_CODE)
    else $error("result read in failure mode not error code");
  AST_CONVLEN: assert property (regRead && regAddr == `SSC_REG_MODE
    |=> convLength == (regRdata[2] ? 14'h2000 : 14'h1000))
    else $error("conversion length does not match resolution");
  AST_DIGITAL_NO_ANA: assert property (cfgPinMode == `SSC_PIN_DIGITAL
    |-> !(sharedOutputPinOe && !sharedOutputPinLow))
    else $error("analogue output in digital-only mode");
  AST_DIS_NO_READ: assert property (cfgPinMode == `SSC_PIN_DISABLED |-> !wireReadGrant)
    else $error("readout granted in disabled mode");
  AST_MEM_FAIL: assert property ($rose(memCheckErr) |-> ##[1:8] failureFlag)
    else $error("memory mismatch not flagged");
endmodule // ssc_ctrl_sva
bind ssc_ctrl ssc_ctrl_sva #(.POR_CYC(POR_CYC)) ssc_ctrl_sva_inst (
  .clk(clk), .resetn(resetn), .regAddr(regAddr), .regRead(regRead), .regRdata(regRdata),
  .memCheckErr(memCheckErr), .cfgPinMode(cfgPinMode), .cfgResolution(cfgResolution),
  .workMode(workMode), .convLength(convLength), .sharedOutputPinOe(sharedOutputPinOe),
  .sharedOutputPinLow(sharedOutputPinLow), .wireReadGrant(wireReadGrant),
  .failureFlag(failureFlag));
`default_nettype wire

// *** ssc_wire_master.sv ***
// behavioural single-wire master standing on the shared output pin
`timescale 1ns/100ps
`default_nettype none
module ssc_wire_master (
  input  wire logic clk,
  input  wire logic doCmd,
  input  wire logic doRead,
  output var  logic enterCmdReq,
  output var  logic wireReadReq
);
  // requests are levels, registered on each clock from doCmd and doRead
  initial enterCmdReq = 1'b0;
  initial wireReadReq = 1'b0;
  always @(posedge clk) begin
    enterCmdReq <= doCmd;
    wireReadReq <= doRead;
  end
endmodule // ssc_wire_master
`default_nettype wire

// *** ssc_ctrl_bench.sv ***
// self-checking testbench for the sensor startup and mode controller
`timescale 1ns/100ps
`default_nettype none
`include "ssc_ctrl_regs.vh"
module ssc_ctrl_bench;
  localparam integer POR = 20, SYS = 4, WIN = 400, WDG = 200, OSCTO = 64;
  reg clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0, oscTick = 1'b0;
  reg convDone = 1'b0, sigCheckOk = 1'b1, memCheckErr = 1'b0, cfgResolution = 1'b0;
  reg doCmd = 1'b0, doRead = 1'b0, oscRun = 1'b1;
  reg [3:0] regAddr = 4'h0, convCnt = 4'h0;
  reg [1:0] cfgPinMode = 2'h0, cfgMuxSeq = 2'h0, divCnt = 2'h0;
  reg [15:0] regWdata = 16'h0000, d;
  reg [14:0] convResult = 15'h0000;
  wire [15:0] regRdata, dacCode;
  wire [13:0] convLength;
  wire [1:0] workMode, muxSelect;
  wire enterCmdReq, wireReadReq, pinOe, pinLow, wireReadGrant, failureFlag;
  integer n_errors = 0, samples_checked = 0, m, i, seed;
  ssc_ctrl #(.POR_CYC(POR), .SYS_CYC(SYS), .WINDOW_CYC(WIN), .WDOG_CYC(WDG),
    .OSC_TIMEOUT(OSCTO)) ssc_ctrl_inst (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .oscTick(oscTick),
    .convDone(convDone), .convResult(convResult), .sigCheckOk(sigCheckOk),
    .memCheckErr(memCheckErr), .enterCmdReq(enterCmdReq), .wireReadReq(wireReadReq),
    .cfgPinMode(cfgPinMode), .cfgResolution(cfgResolution), .cfgMuxSeq(cfgMuxSeq),
    .workMode(workMode), .muxSelect(muxSelect), .convLength(convLength), .dacCode(dacCode),
    .sharedOutputPinOe(pinOe), .sharedOutputPinLow(pinLow),
    .wireReadGrant(wireReadGrant), .failureFlag(failureFlag));
  ssc_wire_master ssc_wire_master_inst (.clk(clk), .doCmd(doCmd), .doRead(doRead),
    .enterCmdReq(enterCmdReq), .wireReadReq(wireReadReq));
  // ************************************************************
  // clock, oscillator ticks every 4 clocks, a conversion every 10 clocks
  // ************************************************************
  always #20 clk = ~clk;
  always @(posedge clk) begin
    divCnt <= divCnt + 2'h1;
    if (oscRun) oscTick <= divCnt[1];
    convDone <= (convCnt == 4'h9);
    convCnt <= (convCnt == 4'h9) ? 4'h0 : convCnt + 4'h1;
  end
  // ************************************************************
  // bus cycles and comparison
  // ************************************************************
  task check(input [15:0] seen, input [15:0] exp, input string msg);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("MISMATCH at %0t: %s", $time, msg);
      end
    end
  endtask
  // analogue code: result clipped to the limits, then shifted into 12.4 form
  function [15:0] expDac(input [14:0] r, input [14:0] lo, input [14:0] hi);
    reg [14:0] c;
    begin
      c = (r < lo) ? lo : (r > hi) ? hi : r;
      expDac = {c, 1'b0};
    end
  endfunction
  task wr(input [3:0] a, input [15:0] v);
    begin
      @(posedge clk); regWrite <= 1'b1; regAddr <= a; regWdata <= v;
      @(posedge clk); regWrite <= 1'b0;
    end
  endtask
  // read data stands only in the cycle after the strobe, so sample mid-cycle
  task rd(input [3:0] a, output [15:0] v);
    begin
      @(posedge clk); regRead <= 1'b1; regAddr <= a;
      @(posedge clk); regRead <= 1'b0;
      @(negedge clk); v = regRdata;
    end
  endtask
  // waiting in run mode keeps the watchdog fed
  task idle(input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        if (k % 50 == 0) wr(`SSC_REG_WDKICK, 16'h0000);
        else @(posedge clk);
      end
    end
  endtask
  task boot(input [1:0] mode, input sigOk);
    reg started;
    begin
      resetn <= 1'b0; cfgPinMode <= mode; sigCheckOk <= sigOk; memCheckErr <= 1'b0;
      doCmd <= 1'b0; doRead <= 1'b0; oscRun <= 1'b1; cfgResolution <= $urandom;
      cfgMuxSeq <= $urandom; convResult <= $urandom;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      repeat (POR - 2) begin
        @(posedge clk); #1 check({15'h0000, pinOe}, 16'h0000, "pin driven in settling");
      end
      started = 1'b0;
      for (i = 0; i < 80 && !started; i = i + 1) begin
        rd(`SSC_REG_STATUS, d);
        started = d[5] | failureFlag;
      end
      check({15'h0000, started}, 16'h0001, "startup never completed");
    end
  endtask
  task final_report;
    begin
      $display("checks %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #(40 * 60000);
    n_errors = n_errors + 1;
    final_report;
  end
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    seed = $urandom(97);
    for (m = 0; m < 4; m = m + 1) begin
      boot(m, 1'b1);
      check({14'h0000, workMode}, 16'h0000, "not in normal mode");
      rd(`SSC_REG_RESULT, d);
      check(d, {1'b0, convResult}, "result read clipped or wrong");
      rd(`SSC_REG_MODE, d);
      check(d, {13'h0000, cfgResolution, cfgPinMode}, "stored mode not loaded");
      check({2'b00, convLength}, cfgResolution ? 16'h2000 : 16'h1000, "conv length");
      check(dacCode, expDac(convResult, 15'h0000, 15'h7FFF), "analogue code");
      check({15'h0000, muxSelect == 2'h3}, 16'h0000, "illegal mux select");
      doRead <= 1'b1;
      idle(20);
      if (m == 0 || m == 3) check({15'h0000, wireReadGrant}, {15'h0000, m == 0}, "readout");
      doRead <= 1'b0;
      if (m == 1) check({15'h0000, pinOe}, 16'h0000, "pin driven in window");
      if (m == 2) check({15'h0000, pinOe & ~pinLow}, 16'h0001, "no analogue in window");
      idle(WIN + 50);
      check({15'h0000, pinOe & ~pinLow}, {15'h0000, m != 0}, "analogue output state");
      if (m == 2) begin
        doCmd <= 1'b1;
        idle(20);
        check({14'h0000, workMode}, 16'h0000, "late command accepted");
        doCmd <= 1'b0;
      end
    end
    // register reset values, write/read back, refused places
    boot(0, 1'b1);
    rd(`SSC_REG_LIMLO, d); check(d, {1'b0, `SSC_LIMLO_RST}, "lower limit reset");
    rd(`SSC_REG_LIMHI, d); check(d, {1'b0, `SSC_LIMHI_RST}, "upper limit reset");
    regWdata <= $urandom;
    wr(`SSC_REG_LIMLO, 16'h1234);
    rd(`SSC_REG_LIMLO, d); check(d, 16'h1234, "lower limit write");
    rd(`SSC_REG_DACCODE, d);
    check(d, expDac(convResult, 15'h1234, 15'h7FFF), "clipped code");
    wr(`SSC_REG_RESULT, 16'h0000);
    rd(`SSC_REG_RESULT, d); check(d, {1'b0, convResult}, "result written");
    rd(4'h8, d); check(d, 16'h0000, "unmapped read");
    memCheckErr <= 1'b1;
    idle(10);
    check({15'h0000, failureFlag}, 16'h0001, "memory mismatch");
    memCheckErr <= 1'b0;
    idle(5);
    check({15'h0000, failureFlag & pinLow}, 16'h0001, "failure not sticky");
    // command entry inside the window
    boot(1, 1'b1);
    doCmd <= 1'b1;
    idle(20);
    check({14'h0000, workMode}, 16'h0001, "command not entered");
    doCmd <= 1'b0;
    // failed signature check
    boot(2, 1'b0);
    check({15'h0000, failureFlag & pinLow}, 16'h0001, "startup error");
    rd(`SSC_REG_RESULT, d); check(d, `SSC_ERROR_CODE, "error code");
    // oscillator stops
    boot(3, 1'b1);
    oscRun <= 1'b0;
    idle(OSCTO * 4);
    check({15'h0000, failureFlag}, 16'h0001, "oscillator fault");
    // watchdog starved
    boot(3, 1'b1);
    repeat (WDG / 2) @(posedge clk);
    check({15'h0000, failureFlag}, 16'h0000, "early watchdog");
    repeat (WDG * 2) @(posedge clk);
    check({15'h0000, failureFlag}, 16'h0001, "watchdog expiry");
    final_report;
  end
endmodule // ssc_ctrl_bench
`default_nettype wire
